// ### design/opc_panel.sv
//
// Contract
// - Key lock blocks every button, power too
// - Master clear resets CPU and enable mask
// - Error lights clear lamp; clear darkens it
// - Restart in stop starts at 20
// - Load starts autoload; lamp lit while loading
// - Continue runs from counter on mask level
// - Master clear then continue runs level zero
// - Stop halts; stop lamp lit while stopped
// - Switch register readable into accumulator
// - Lamp register shows data; program writes user
// - Selector buttons choose view; diode marks choice
// - Active levels view with per-level afterglow
// - Fetch address and DMA address views
// - User write disturbs other selected view
// - Data bus view and instruction register view
// - Stop examine uses latched address, zeroed on stop
// - Running examine uses switches, resampled each tick
// - Working register view for level, per tick
// - Plus minus step level; outside shows active
// - Running level is highest enabled requested level
// - Set address latches switches in stop
//
`timescale 1ns/1ps
`default_nettype none

module opc_panel #(
    parameter int TICK_CYCLES = opc_pkg::PANEL_TICK_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic        keyLockEngaged,
    input  wire logic        btnPower,
    input  wire logic        btnMasterClear,
    input  wire logic        btnRestart,
    input  wire logic        btnLoad,
    input  wire logic        btnContinue,
    input  wire logic        btnStop,
    input  wire logic        btnSetAddress,
    input  wire logic        btnPlus,
    input  wire logic        btnMinus,
    input  wire logic [15:0] btnSelect,
    input  wire logic [17:0] switchPins,
    input  wire logic [3:0]  autoloadSelectSwitches,
    input  wire logic        cpuErrorEvent,
    input  wire logic        loadDone,
    input  wire logic [15:0] levelRequestSet,
    input  wire logic        fetchValid,
    input  wire logic [17:0] fetchAddr,
    input  wire logic [17:0] dmaAddr,
    input  wire logic        dataValid,
    input  wire logic [15:0] dataBusWord,
    input  wire logic [15:0] instrReg,
    input  wire logic [15:0] workRegData,
    input  wire logic        memReadValid,
    input  wire logic [15:0] memReadData,
    input  wire logic        consoleExamineValid,
    input  wire logic [17:0] consoleExamineAddr,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    output logic             cpuMasterClear,
    output logic             cpuStopRequest,
    output logic             cpuStartPulse,
    output logic             cpuStartFromPc,
    output logic      [17:0] cpuStartAddr,
    output logic             autoloadStart,
    output logic      [3:0]  autoloadDevice,
    output logic      [3:0]  runLevel,
    output logic             memReadReq,
    output logic      [17:0] memReadAddr,
    output logic      [3:0]  workRegLevel,
    output logic      [2:0]  workRegSel,
    output logic      [17:0] lampData,
    output logic      [15:0] selectorLeds,
    output logic      [3:0]  levelTens,
    output logic      [3:0]  levelOnes,
    output logic             lampMasterClear,
    output logic             lampLoad,
    output logic             lampStop,
    output logic             lampContinue,
    output logic             powerOn
);

    // ******************************
    // Elaboration checks
    // ******************************
    generate
        if (TICK_CYCLES < 2 || TICK_CYCLES > 1048575) begin : g_chk
            $error("TICK_CYCLES must lie in 2 .. 2**20-1");
        end
    endgenerate

    // ******************************
    // Pin synchronisers
    // ******************************
    logic [opc_pkg::BTN_W-1:0] btnPress;
    logic [22:0]               levelPins;
    logic [17:0]               switchSync;
    logic [3:0]                autoloadSync;
    logic                      lockSync;

    opc_sync #(.WIDTH(opc_pkg::BTN_W)) u_btn (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .pinIn    ({btnPower, btnMasterClear, btnRestart, btnLoad, btnContinue,
                    btnStop, btnSetAddress, btnPlus, btnMinus, btnSelect}),
        .levelOut (),
        .pressOut (btnPress)
    );

    opc_sync #(.WIDTH(23)) u_lvl (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .pinIn    ({keyLockEngaged, autoloadSelectSwitches, switchPins}),
        .levelOut (levelPins),
        .pressOut ()
    );

    assign switchSync   = levelPins[17:0];
    assign autoloadSync = levelPins[21:18];
    assign lockSync     = levelPins[22];

    // ******************************
    // State
    // ******************************
    opc_pkg::opc_run_e  runState, next_runState;
    opc_pkg::opc_view_e view, next_view;
    logic [15:0] levelEnable, next_levelEnable;
    logic [15:0] levelRequest, next_levelRequest;
    logic [17:0] examAddr, next_examAddr;
    logic [4:0]  levelSel, next_levelSel;
    logic [19:0] tickCnt, next_tickCnt;
    logic        tick, next_tick;
    logic        workSample, next_workSample;
    logic [1:0]  glow [16];
    logic [15:0] glowLit;
    logic [3:0]  prioLevel;
    logic [3:0]  shownLevel;
    logic [24:0] act;
    logic [31:0] next_regRdData;
    logic [17:0] next_lampData;
    logic        next_lampMasterClear;
    logic        next_powerOn;
    logic        next_mclear, next_stopReq, next_start, next_fromPc;
    logic [17:0] next_startAddr;
    logic        next_alStart;
    logic [3:0]  next_alDevice;

    // ******************************
    // Running level
    // ******************************
    always_comb begin
        prioLevel = 4'h0;
        for (int i = 0; i < opc_pkg::LEVELS; i++) begin
            if (levelEnable[i] && levelRequest[i]) begin
                prioLevel = 4'(i);
            end
        end
    end

    // Buttons count only while unlocked
    assign act = lockSync ? 25'h0 : btnPress;

    // ******************************
    // Control next state
    // ******************************
    always_comb begin
        next_runState        = runState;
        next_levelEnable     = levelEnable;
        next_levelRequest    = levelRequest | levelRequestSet;
        next_examAddr        = examAddr;
        next_lampMasterClear = lampMasterClear;
        next_powerOn         = powerOn;
        next_mclear          = 1'b0;
        next_stopReq         = 1'b0;
        next_start           = 1'b0;
        next_fromPc          = cpuStartFromPc;
        next_startAddr       = cpuStartAddr;
        next_alStart         = 1'b0;
        next_alDevice        = autoloadDevice;
        next_view            = view;
        next_levelSel        = levelSel;
        if (regWr && regAddr == opc_pkg::OFS_ENABLE) begin
            next_levelEnable = regWrData[15:0];
        end
        // Hardware requests win over a program write in the same cycle
        if (regWr && regAddr == opc_pkg::OFS_REQUEST) begin
            next_levelRequest = regWrData[15:0] | levelRequestSet;
        end
        if (act[opc_pkg::BTN_POWER]) begin
            next_powerOn = ~powerOn;
        end
        if (act[opc_pkg::BTN_MCLEAR]) begin
            next_mclear          = 1'b1;
            next_levelEnable     = 16'h0;
            next_runState        = opc_pkg::RUN_STOP;
            next_examAddr        = 18'h0;
            next_lampMasterClear = 1'b0;
        end else if (act[opc_pkg::BTN_STOP]) begin
            if (runState != opc_pkg::RUN_STOP) begin
                next_runState = opc_pkg::RUN_STOP;
                next_stopReq  = 1'b1;
                next_examAddr = 18'h0;
            end
        end else if (runState == opc_pkg::RUN_STOP) begin
            // Restart while running is dropped on purpose
            if (act[opc_pkg::BTN_RESTART]) begin
                next_start     = 1'b1;
                next_fromPc    = 1'b0;
                next_startAddr = opc_pkg::RESTART_ADDR;
                next_runState  = opc_pkg::RUN_GO;
            end else if (act[opc_pkg::BTN_CONTINUE]) begin
                next_start     = 1'b1;
                next_fromPc    = 1'b1;
                next_startAddr = 18'h0;
                next_runState  = opc_pkg::RUN_GO;
            end else if (act[opc_pkg::BTN_LOAD]) begin
                next_alStart  = 1'b1;
                next_alDevice = autoloadSync;
                next_runState = opc_pkg::RUN_LOAD;
            end else if (act[opc_pkg::BTN_SETADDR]) begin
                next_examAddr = switchSync;
            end
        end else if (runState == opc_pkg::RUN_LOAD && loadDone) begin
            next_runState = opc_pkg::RUN_STOP;
            next_examAddr = 18'h0;
        end
        if (consoleExamineValid) begin
            next_examAddr = consoleExamineAddr;
        end
        // An error in the same cycle as the clear keeps the lamp lit
        if (cpuErrorEvent) begin
            next_lampMasterClear = 1'b1;
        end
        // Lowest index loops last, so the lowest pressed button wins
        for (int i = 15; i >= 0; i--) begin
            if (act[opc_pkg::BTN_SEL_LSB + i]) begin
                next_view = opc_pkg::opc_view_e'(4'(i));
            end
        end
        if (act[opc_pkg::BTN_PLUS]) begin
            if (levelSel == opc_pkg::LEVEL_BELOW) begin
                next_levelSel = 5'h0;
            end else if (levelSel != opc_pkg::LEVEL_ABOVE) begin
                next_levelSel = levelSel + 5'h1;
            end
        end else if (act[opc_pkg::BTN_MINUS]) begin
            if (levelSel == 5'h0) begin
                next_levelSel = opc_pkg::LEVEL_BELOW;
            end else if (levelSel != opc_pkg::LEVEL_BELOW) begin
                next_levelSel = levelSel - 5'h1;
            end
        end
    end

    // ******************************
    // Panel tick and afterglow
    // ******************************
    always_comb begin
        next_tick       = 1'b0;
        next_tickCnt    = tickCnt + 20'h1;
        next_workSample = tick;
        if (tickCnt == 20'(TICK_CYCLES - 1)) begin
            next_tickCnt = 20'h0;
            next_tick    = 1'b1;
        end
    end

    generate
        for (genvar g = 0; g < opc_pkg::LEVELS; g++) begin : g_glow
            logic [1:0] next_glow;
            // Afterglow keeps a lone instruction visible
            always_comb begin
                next_glow = glow[g];
                if (runState == opc_pkg::RUN_GO && prioLevel == 4'(g)) begin
                    next_glow = opc_pkg::GLOW_TICKS;
                end else if (tick && glow[g] != 2'h0) begin
                    next_glow = glow[g] - 2'h1;
                end
            end
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    glow[g] <= 2'h0;
                end else if (clkEn) begin
                    glow[g] <= next_glow;
                end
            end
            assign glowLit[g] = (glow[g] != 2'h0);
        end
    endgenerate

    // ******************************
    // Display and bus next state
    // ******************************
    assign shownLevel = levelSel[4] ? prioLevel : levelSel[3:0];

    always_comb begin
        next_lampData = lampData;
        case (view)
            opc_pkg::VIEW_ACTIVE: if (tick) next_lampData = {2'h0, glowLit};
            opc_pkg::VIEW_DMA:    if (tick) next_lampData = dmaAddr;
            opc_pkg::VIEW_FETCH:  if (fetchValid) next_lampData = fetchAddr;
            opc_pkg::VIEW_USER:   next_lampData = lampData;
            opc_pkg::VIEW_DATA:   if (dataValid) next_lampData = {2'h0, dataBusWord};
            opc_pkg::VIEW_EXAM:   if (memReadValid) next_lampData = {2'h0, memReadData};
            opc_pkg::VIEW_INSTR:  if (tick) next_lampData = {2'h0, instrReg};
            opc_pkg::VIEW_SPARE:  next_lampData = 18'h0;
            default:              if (workSample) next_lampData = {2'h0, workRegData};
        endcase
        // A user write shows until the view's next sample
        if (regWr && regAddr == opc_pkg::OFS_LAMP) begin
            next_lampData = {2'h0, regWrData[15:0]};
        end
        next_regRdData = 32'h0;
        if (regRd) begin
            case (regAddr)
                opc_pkg::OFS_SWITCH:  next_regRdData = {14'h0, switchSync};
                opc_pkg::OFS_LAMP:    next_regRdData = {14'h0, lampData};
                opc_pkg::OFS_ENABLE:  next_regRdData = {16'h0, levelEnable};
                opc_pkg::OFS_REQUEST: next_regRdData = {16'h0, levelRequest};
                opc_pkg::OFS_STATUS: begin
                    next_regRdData[opc_pkg::STW_LEVEL_LSB +: 4] = prioLevel;
                    next_regRdData[opc_pkg::STW_STOP]  = (runState == opc_pkg::RUN_STOP);
                    next_regRdData[opc_pkg::STW_RUN]   = (runState == opc_pkg::RUN_GO);
                    next_regRdData[opc_pkg::STW_LOAD]  = (runState == opc_pkg::RUN_LOAD);
                    next_regRdData[opc_pkg::STW_ERROR] = lampMasterClear;
                    next_regRdData[opc_pkg::STW_LOCK]  = lockSync;
                    next_regRdData[opc_pkg::STW_POWER] = powerOn;
                    next_regRdData[opc_pkg::STW_VIEW_LSB +: 4] = view;
                end
                default: next_regRdData = 32'h0;
            endcase
        end
    end

    // ******************************
    // Registers
    // ******************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            runState        <= opc_pkg::RUN_STOP;
            view            <= opc_pkg::VIEW_ACTIVE;
            levelEnable     <= 16'h0;
            levelRequest    <= 16'h0;
            examAddr        <= 18'h0;
            levelSel        <= 5'h0;
            tickCnt         <= 20'h0;
            tick            <= 1'b0;
            workSample      <= 1'b0;
            regRdData       <= 32'h0;
            cpuMasterClear  <= 1'b0;
            cpuStopRequest  <= 1'b0;
            cpuStartPulse   <= 1'b0;
            cpuStartFromPc  <= 1'b0;
            cpuStartAddr    <= 18'h0;
            autoloadStart   <= 1'b0;
            autoloadDevice  <= 4'h0;
            runLevel        <= 4'h0;
            memReadReq      <= 1'b0;
            memReadAddr     <= 18'h0;
            workRegLevel    <= 4'h0;
            workRegSel      <= 3'h0;
            lampData        <= 18'h0;
            selectorLeds    <= 16'h1;
            levelTens       <= 4'h0;
            levelOnes       <= 4'h0;
            lampMasterClear <= 1'b0;
            lampLoad        <= 1'b0;
            lampStop        <= 1'b1;
            lampContinue    <= 1'b0;
            powerOn         <= 1'b1;
        end else if (clkEn) begin
            runState        <= next_runState;
            view            <= next_view;
            levelEnable     <= next_levelEnable;
            levelRequest    <= next_levelRequest;
            examAddr        <= next_examAddr;
            levelSel        <= next_levelSel;
            tickCnt         <= next_tickCnt;
            tick            <= next_tick;
            workSample      <= next_workSample;
            regRdData       <= next_regRdData;
            cpuMasterClear  <= next_mclear;
            cpuStopRequest  <= next_stopReq;
            cpuStartPulse   <= next_start;
            cpuStartFromPc  <= next_fromPc;
            cpuStartAddr    <= next_startAddr;
            autoloadStart   <= next_alStart;
            autoloadDevice  <= next_alDevice;
            runLevel        <= prioLevel;
            memReadReq      <= next_tick && view == opc_pkg::VIEW_EXAM;
            memReadAddr     <= (runState == opc_pkg::RUN_STOP) ? examAddr : switchSync;
            workRegLevel    <= shownLevel;
            workRegSel      <= 3'(view - opc_pkg::VIEW_W_STW);
            lampData        <= next_lampData;
            selectorLeds    <= 16'h1 << next_view;
            levelTens       <= (shownLevel > 4'h9) ? 4'h1 : 4'h0;
            levelOnes       <= (shownLevel > 4'h9) ? shownLevel - 4'ha : shownLevel;
            lampMasterClear <= next_lampMasterClear;
            lampLoad        <= (next_runState == opc_pkg::RUN_LOAD);
            lampStop        <= (next_runState == opc_pkg::RUN_STOP);
            lampContinue    <= (next_runState == opc_pkg::RUN_GO);
            powerOn         <= next_powerOn;
        end
    end

endmodule

`default_nettype wire

// ### design/opc_pkg.sv
package opc_pkg;

    // ******************************
    // Timing
    // ******************************
    localparam int          CLK_KHZ           = 10000;
    localparam int          PANEL_TICK_MS     = 20;
    localparam int          PANEL_TICK_CYCLES = PANEL_TICK_MS * CLK_KHZ;
    localparam logic [1:0]  GLOW_TICKS        = 2'h2;

    // ******************************
    // Widths and fixed values
    // ******************************
    localparam int           LEVELS       = 16;
    localparam int           SW_W         = 18;
    localparam int           DATA_W       = 16;
    localparam int           AUTOLOAD_W   = 4;
    localparam logic [17:0]  RESTART_ADDR = 18'h14;
    localparam logic [4:0]   LEVEL_ABOVE  = 5'h10;
    localparam logic [4:0]   LEVEL_BELOW  = 5'h1f;

    // ******************************
    // Button vector positions
    // ******************************
    localparam int BTN_SEL_LSB  = 0;
    localparam int BTN_MINUS    = 16;
    localparam int BTN_PLUS     = 17;
    localparam int BTN_SETADDR  = 18;
    localparam int BTN_STOP     = 19;
    localparam int BTN_CONTINUE = 20;
    localparam int BTN_LOAD     = 21;
    localparam int BTN_RESTART  = 22;
    localparam int BTN_MCLEAR   = 23;
    localparam int BTN_POWER    = 24;
    localparam int BTN_W        = 25;

    // ******************************
    // Register map and status_word fields
    // ******************************
    localparam logic [7:0] OFS_SWITCH  = 8'h00;
    localparam logic [7:0] OFS_LAMP    = 8'h04;
    localparam logic [7:0] OFS_ENABLE  = 8'h08;
    localparam logic [7:0] OFS_REQUEST = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;

    localparam int STW_LEVEL_LSB = 0;
    localparam int STW_STOP      = 4;
    localparam int STW_RUN       = 5;
    localparam int STW_LOAD      = 6;
    localparam int STW_ERROR     = 7;
    localparam int STW_LOCK      = 8;
    localparam int STW_POWER     = 9;
    localparam int STW_VIEW_LSB  = 12;

    typedef enum logic [1:0] {
        RUN_STOP = 2'b00,
        RUN_GO   = 2'b01,
        RUN_LOAD = 2'b10
    } opc_run_e;

    typedef enum logic [3:0] {
        VIEW_ACTIVE = 4'b0000,
        VIEW_DMA    = 4'b0001,
        VIEW_FETCH  = 4'b0010,
        VIEW_USER   = 4'b0011,
        VIEW_DATA   = 4'b0100,
        VIEW_EXAM   = 4'b0101,
        VIEW_INSTR  = 4'b0110,
        VIEW_W_STW  = 4'b0111,
        VIEW_W_P    = 4'b1000,
        VIEW_W_L    = 4'b1001,
        VIEW_W_B    = 4'b1010,
        VIEW_W_X    = 4'b1011,
        VIEW_W_T    = 4'b1100,
        VIEW_W_A    = 4'b1101,
        VIEW_W_D    = 4'b1110,
        VIEW_SPARE  = 4'b1111
    } opc_view_e;

endpackage

// ### design/opc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module opc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] levelOut,
    output logic      [WIDTH-1:0] pressOut
);

    // ******************************
    // Two-stage synchroniser and press detector
    // ******************************
    // Presses come from the settled stage only
    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] stageTwo;
    logic [WIDTH-1:0] history;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("opc_sync needs WIDTH of at least one");
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stageOne <= '0;
            stageTwo <= '0;
            history  <= '0;
        end else if (clkEn) begin
            stageOne <= pinIn;
            stageTwo <= stageOne;
            history  <= stageTwo;
        end
    end

    always_comb begin
        levelOut = stageTwo;
        pressOut = stageTwo & ~history;
    end

endmodule

`default_nettype wire

// ### tb/opc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module opc_chk (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        keyLockEngaged,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    input wire logic        cpuMasterClear,
    input wire logic        cpuStopRequest,
    input wire logic        cpuStartPulse,
    input wire logic        cpuStartFromPc,
    input wire logic [17:0] cpuStartAddr,
    input wire logic        autoloadStart,
    input wire logic [15:0] selectorLeds,
    input wire logic        lampLoad,
    input wire logic        lampStop,
    input wire logic        lampContinue
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Four samples: long enough for the lock to pass its synchroniser
    sequence lockHeld; keyLockEngaged [*4]; endsequence
    sequence anyAction; cpuMasterClear || cpuStartPulse || cpuStopRequest || autoloadStart; endsequence
    lock_ignore_a: assert property (lockHeld |=> not anyAction) else $error("action while locked");
    clear_state_a: assert property (cpuMasterClear |-> lampStop && !lampContinue) else $error("clear state");
    restart_addr_a: assert property (cpuStartPulse && !cpuStartFromPc |-> cpuStartAddr == 18'h14) else $error("rst adr");
    start_stop_a: assert property (cpuStartPulse |-> $past(lampStop) && lampContinue) else $error("start");
    load_lamp_a: assert property (autoloadStart |-> lampLoad && $past(lampStop)) else $error("load lamp");
    stop_lamp_a: assert property (cpuStopRequest |-> lampStop && !lampContinue) else $error("stop lamp");
    select_one_a: assert property ($onehot(selectorLeds)) else $error("selector");
    read_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0) else $error("read idle");
endmodule
`default_nettype wire

// ### tb/opc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module opc_cpu_model (
    input  wire logic        clk_sys,
    input  wire logic        memReadReq,
    input  wire logic [17:0] memReadAddr,
    output logic             memReadValid,
    output logic      [15:0] memReadData,
    input  wire logic        autoloadStart,
    output logic             loadDone
);
    logic [5:0] loadCnt = 6'h0;
    // Word scrambles its address so a wrong one shows
    always @(posedge clk_sys) begin
        memReadValid <= memReadReq;
        memReadData  <= memReadAddr[15:0] ^ 16'h5a5a;
        loadCnt      <= autoloadStart ? 6'h3f : loadCnt - 6'(loadCnt != 6'h0);
        loadDone     <= loadCnt == 6'h1;
    end
endmodule
`default_nettype wire

// ### tb/operator_panel_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module operator_panel_control_test;
    logic clk_sys = 0, sys_rst = 1, clkEn = 1, keyLockEngaged = 0, cpuErrorEvent = 0, regWr = 0, regRd = 0;
    logic fetchValid = 0, dataValid = 0, consoleExamineValid = 0, memReadReq, memReadValid, loadDone, autoloadStart;
    logic lampMasterClear, lampLoad, lampStop, lampContinue, powerOn;
    logic [24:0] btn = 25'h0;
    logic [15:0] levelRequestSet = 16'h0, workRegData = 16'h0, dataBusWord = 16'h0, instrReg = 16'h0;
    logic [15:0] memReadData, selectorLeds, en, rq;
    logic [17:0] switchPins = 18'h0, fetchAddr = 18'h0, dmaAddr = 18'h0, consoleExamineAddr = 18'h0, memReadAddr, lampData;
    logic [31:0] regWrData = 32'h0, regRdData, rv, seed = 32'hd610;
    logic [7:0] regAddr = 8'h0;
    logic [3:0] autoloadSelectSwitches = 4'h0, autoloadDevice, levelOnes;
    int numErrors = 0, cmpCount = 0, cyc = 0;
    opc_panel #(.TICK_CYCLES(8)) opc_panel_inst (.*, .btnPower(btn[24]), .btnMasterClear(btn[23]), .btnRestart(btn[22]),
        .btnLoad(btn[21]), .btnContinue(btn[20]), .btnStop(btn[19]), .btnSetAddress(btn[18]), .btnPlus(btn[17]),
        .btnMinus(btn[16]), .btnSelect(btn[15:0]), .cpuStartAddr(), .runLevel(), .workRegLevel(), .workRegSel(),
        .levelTens(), .cpuMasterClear(), .cpuStopRequest(), .cpuStartPulse(), .cpuStartFromPc());
    opc_cpu_model opc_cpu_model_inst (.*);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    function automatic logic [3:0] top(input logic [15:0] m);
        top = 4'h0;
        for (int i = 0; i < 16; i++) if (m[i]) top = 4'(i);
    endfunction
    task automatic reportAndStop();
        $display("errors %0d of %0d checks", numErrors, cmpCount);
        if (numErrors == 0 && cmpCount > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmpCount++;
        if (s !== e) begin
            numErrors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // Outlasts the synchroniser
    task automatic press(input logic [24:0] m);
        @(posedge clk_sys) btn <= m;
        repeat (5) @(posedge clk_sys);
        btn <= 25'h0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) {regWr, regRd, regAddr, regWrData} <= {w, !w, a, d};
        @(posedge clk_sys) {regWr, regRd} <= 2'b00;
        #1 rv = regRdData;
    endtask
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        seed <= xs(seed);
        {fetchValid, dataValid, fetchAddr, dmaAddr[11:0]} <= seed;
        {dataBusWord, instrReg} <= xs(seed);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            numErrors++;
            reportAndStop();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        {sys_rst, cpuErrorEvent} <= 2'b01;
        @(posedge clk_sys) cpuErrorEvent <= 1'b0;
        press(25'h0);
        chk("errLamp", 1, lampMasterClear);
        for (int i = 0; i < 6; i++) begin
            en = seed[15:0] | {16{i == 1}};
            rq = seed[31:16] & {16{i != 0}};
            bus(1, opc_pkg::OFS_ENABLE, {16'h0, en});
            bus(1, opc_pkg::OFS_REQUEST, {16'h0, rq});
            bus(0, opc_pkg::OFS_STATUS, 0);
            chk("level", top(en & rq), rv[3:0]);
        end
        press(25'h800000);
        chk("clrLamp", 0, lampMasterClear);
        bus(0, opc_pkg::OFS_ENABLE, 0);
        chk("enable", 0, rv);
        @(posedge clk_sys) {switchPins, autoloadSelectSwitches} <= seed[21:0];
        press(25'h220);
        chk("leds", 16'h20, selectorLeds);
        press(25'h40000);
        repeat (30) @(posedge clk_sys);
        #1 chk("exam", switchPins[15:0] ^ 16'h5a5a, lampData[15:0]);
        bus(0, opc_pkg::OFS_SWITCH, 0);
        chk("switch", switchPins, rv);
        bus(0, 8'h40, 0);
        chk("unmapped", 0, rv);
        press(25'h8);
        en = seed[15:0];
        bus(1, opc_pkg::OFS_LAMP, {16'h0, en});
        chk("lamp", en, lampData[15:0]);
        press(25'h20000);
        chk("ones", 1, levelOnes);
        press(25'h200000);
        chk("loadLamp", 1, lampLoad);
        chk("device", autoloadSelectSwitches, autoloadDevice);
        repeat (70) @(posedge clk_sys);
        #1 chk("loadEnd", 0, lampLoad);
        keyLockEngaged <= 1'b1;
        press(25'h1100000);
        chk("locked", 0, lampContinue);
        chk("lockPwr", 1, powerOn);
        keyLockEngaged <= 1'b0;
        press(25'h100000);
        chk("run", 1, lampContinue);
        press(25'h400000);
        press(25'h80000);
        chk("stop", 1, lampStop);
        press(25'h400000);
        chk("restart", 1, lampContinue);
        reportAndStop();
    end
endmodule
bind opc_panel opc_chk opc_chk_inst (.clk_sys, .sys_rst, .keyLockEngaged, .regRd, .regRdData, .cpuMasterClear,
    .cpuStopRequest, .cpuStartPulse, .cpuStartFromPc, .cpuStartAddr, .autoloadStart, .selectorLeds, .lampLoad,
    .lampStop, .lampContinue);
`default_nettype wire
